/* File: core/scc_core.sv */
// Command decoder, motion sequencer, clock divider and power states
`timescale 1ns/1ps
module scc_core #(
  parameter int SUSPEND_CYCLES = scc_pkg::SUSPEND_CYC
) (
  input  wire logic       CLK,
  input  wire logic       SYS_RST,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  input  wire logic [7:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  output logic      [7:0] REG_RDATA,
  input  wire logic [7:0] IMG_DATA,
  output logic            IMG_RD,
  input  wire logic [1:0] PAPER_SENSE,
  input  wire logic [1:0] SENSE_STOP_EN,
  input  wire logic [7:0] EJECT_STEPS,
  input  wire logic       COLOR_PIXEL_RATE,
  input  wire logic       MOTOR_OE_CFG,
  input  wire logic       RESET_PIN,
  input  wire logic       USB_ACTIVITY,
  input  wire logic [5:0] MISC_IO_IN,
  input  wire logic [2:0] MISC_OUT_VAL,
  output logic      [5:0] MISC_IO_OUT,
  output logic      [5:0] MISC_IO_OE,
  output logic            CORE_TICK,
  output logic            MOTOR_STEP,
  output logic            MOTOR_DIR,
  output logic            MOTOR_OE,
  output logic            SCANNING,
  output logic            MOTOR_BUSY,
  output logic            ANALOG_PWR_DN,
  output logic            CORE_CLK_RUN,
  output logic            DRAM_REFRESH_EN,
  output logic            OSC_RUN,
  output logic            USB_XCVR_RST,
  output logic            REMOTE_WAKE,
  output logic      [9:0] PIXEL_PERIOD,
  output logic      [8:0] LINE_MULT
);
  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [5:0] s1;        // First stage: sense, reset pin, activity
  logic [5:0] s2;        // Second stage
  logic [5:0] sd;        // Delayed copy for edge detection
  logic [5:0] next_s1;
  // Pin inputs in one vector: [1:0] sense, [2] reset pin, [3] activity, [5:4] unused
  always_comb begin
    next_s1 = {2'b00, USB_ACTIVITY, RESET_PIN, PAPER_SENSE};
  end
  logic [2:0] m1;        // Misc inputs 1-3, first stage
  logic [2:0] m2;
  logic [2:0] md;
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      s1 <= 6'h00;
      s2 <= 6'h00;
      sd <= 6'h00;
      m1 <= 3'h0;
      m2 <= 3'h0;
      md <= 3'h0;
    end else begin
      s1 <= next_s1;
      s2 <= s1;
      sd <= s2;
      m1 <= MISC_IO_IN[2:0];
      m2 <= m1;
      md <= m2;
    end
  end
  // Power-on from supply or a completed high-low pulse on the reset pin
  logic por;
  assign por = SYS_RST | (sd[2] & ~s2[2]);
  logic [1:0] sense_rise;
  assign sense_rise = s2[1:0] & ~sd[1:0] & SENSE_STOP_EN;
  // ****************************************
  // Registers and motion state
  // ****************************************
  logic [7:0]  cmd_reg, next_cmd;
  logic [7:0]  cdiv, next_cdiv;
  logic [7:0]  lte, next_lte;
  logic [15:0] ffs, next_ffs;
  logic [15:0] mlen, next_mlen;
  scc_pkg::scc_state_type state, next_state;
  logic [15:0] step_cnt, next_step_cnt;   // Full steps moved in this phase
  logic [15:0] tick_cnt, next_tick_cnt;   // Core ticks inside one step
  logic        step, next_step;
  logic [6:0]  acc, next_acc;             // Fractional divider phase
  logic        tick, next_tick;
  logic [16:0] idle_cnt, next_idle_cnt;
  logic        susp, next_susp;
  logic        inited, next_inited;
  logic        wake, next_wake;
  logic [7:0]  rdata, next_rdata;
  logic        cmd_wr;
  logic        stepping;
  logic [15:0] ffs_eff;
  logic [6:0]  div_half;
  assign cmd_wr   = REG_WR & (REG_ADDR == scc_pkg::ADDR_CMD);
  assign ffs_eff  = (ffs == 16'h0000) ? 16'h0001 : ffs;
  assign div_half = {1'b0, cdiv[5:0]} + 7'h02;
  // Decode a command byte into the state it starts
  function automatic scc_pkg::scc_state_type decode(input logic [7:0] c, input logic [15:0] ml);
    case (c[3:0])
      scc_pkg::CMD_FWD:  decode = scc_pkg::ST_FWD;
      scc_pkg::CMD_REV:  decode = scc_pkg::ST_REV;
      scc_pkg::CMD_PFWD: decode = scc_pkg::ST_PFWD;
      scc_pkg::CMD_PREV: decode = scc_pkg::ST_PREV;
      scc_pkg::CMD_SCAN: decode = (ml == 16'h0000) ? scc_pkg::ST_SCAN : scc_pkg::ST_LEAD;
      default:           decode = scc_pkg::ST_IDLE;
    endcase
    if (c[scc_pkg::BIT_SRST]) begin
      decode = scc_pkg::ST_IDLE;
    end
  endfunction : decode
  // Next-value logic for registers, divider, sequencer and power states
  always_comb begin
    next_cmd      = cmd_reg;
    next_cdiv     = cdiv;
    next_lte      = lte;
    next_ffs      = ffs;
    next_mlen     = mlen;
    next_state    = state;
    next_step_cnt = step_cnt;
    next_tick_cnt = tick_cnt;
    next_step     = 1'b0;
    next_tick     = 1'b0;
    next_acc      = acc;
    next_idle_cnt = idle_cnt;
    next_susp     = susp;
    next_inited   = inited | REG_WR;
    next_wake     = 1'b0;
    next_rdata    = rdata;
    // Divider: average rate 2/(code+2) of the clock
    if (CORE_CLK_RUN) begin
      if (acc >= div_half) begin
        // A smaller code written mid-count would otherwise burst ticks
        next_acc  = 7'h00;
        next_tick = 1'b1;
      end else if (acc + 7'h02 >= div_half) begin
        next_acc  = acc + 7'h02 - div_half;
        next_tick = 1'b1;
      end else begin
        next_acc = acc + 7'h02;
      end
    end
    // Step pacing counts core ticks; the step pulse itself is on the fast clock
    stepping = (state != scc_pkg::ST_IDLE) && (state != scc_pkg::ST_SCAN);
    if (stepping && tick) begin
      if (tick_cnt + 16'h0001 >= ffs_eff) begin
        next_tick_cnt = 16'h0000;
        next_step     = 1'b1;
      end else begin
        next_tick_cnt = tick_cnt + 16'h0001;
      end
    end
    if (step) begin
      next_step_cnt = step_cnt + 16'h0001;
      case (state)
        scc_pkg::ST_PFWD, scc_pkg::ST_PREV: begin
          if (next_step_cnt >= mlen) next_state = scc_pkg::ST_IDLE;
        end
        scc_pkg::ST_LEAD: begin
          if (next_step_cnt >= mlen) begin
            next_state    = scc_pkg::ST_SCAN;
            next_step_cnt = 16'h0000;
          end
        end
        scc_pkg::ST_EJECT: begin
          if (next_step_cnt >= {8'h00, EJECT_STEPS}) next_state = scc_pkg::ST_IDLE;
        end
        default: begin
        end
      endcase
    end
    // Enabled sensor going true ends movement except during eject; sensor 2 may eject first
    if (|sense_rise) begin
      case (state)
        scc_pkg::ST_FWD, scc_pkg::ST_PFWD: begin
          if (sense_rise[1] && EJECT_STEPS != 8'h00) begin
            next_state    = scc_pkg::ST_EJECT;
            next_step_cnt = 16'h0000;
          end else begin
            next_state = scc_pkg::ST_IDLE;
          end
        end
        scc_pkg::ST_REV, scc_pkg::ST_PREV, scc_pkg::ST_LEAD, scc_pkg::ST_SCAN: begin
          next_state = scc_pkg::ST_IDLE;
        end
        default: begin
        end
      endcase
    end
    // Register writes; a command write restarts the sequencer
    if (REG_WR) begin
      case (REG_ADDR)
        scc_pkg::ADDR_CMD: begin
          next_cmd      = REG_WDATA;
          next_state    = decode(REG_WDATA, mlen);
          next_step_cnt = 16'h0000;
          next_tick_cnt = 16'h0000;
        end
        scc_pkg::ADDR_CDIV:    next_cdiv = REG_WDATA;
        scc_pkg::ADDR_LTE:     next_lte = REG_WDATA;
        scc_pkg::ADDR_FFS_HI:  next_ffs[15:8] = REG_WDATA;
        scc_pkg::ADDR_FFS_LO:  next_ffs[7:0] = REG_WDATA;
        scc_pkg::ADDR_MLEN_HI: next_mlen[15:8] = REG_WDATA;
        scc_pkg::ADDR_MLEN_LO: next_mlen[7:0] = REG_WDATA;
        default: begin
        end
      endcase
    end
    // Soft reset holds the sequencer idle and the divider parked
    if (cmd_reg[scc_pkg::BIT_SRST] && !cmd_wr) begin
      next_state = scc_pkg::ST_IDLE;
      next_acc   = 7'h00;
    end
    // Register read answers one cycle later
    if (REG_RD) begin
      case (REG_ADDR)
        scc_pkg::ADDR_IMAGE:   next_rdata = IMG_DATA;
        scc_pkg::ADDR_CMD:     next_rdata = cmd_reg;
        scc_pkg::ADDR_CDIV:    next_rdata = cdiv;
        scc_pkg::ADDR_LTE:     next_rdata = lte;
        scc_pkg::ADDR_FFS_HI:  next_rdata = ffs[15:8];
        scc_pkg::ADDR_FFS_LO:  next_rdata = ffs[7:0];
        scc_pkg::ADDR_MLEN_HI: next_rdata = mlen[15:8];
        scc_pkg::ADDR_MLEN_LO: next_rdata = mlen[7:0];
        default:               next_rdata = 8'h00;
      endcase
    end
    // Suspend after long bus silence; activity wakes it
    if (s2[3]) begin
      next_idle_cnt = 17'h0_0000;
      next_susp     = 1'b0;
    end else if (!susp) begin
      if (idle_cnt + 17'h0_0001 >= 17'(SUSPEND_CYCLES)) begin
        next_susp = 1'b1;
      end else begin
        next_idle_cnt = idle_cnt + 17'h0_0001;
      end
    end
    // Spare input rise requests wakeup only after software touched the part
    if (susp && inited && |(m2 & ~md)) next_wake = 1'b1;
    // Entering suspend forces defaults, reset and standby bits set
    if (next_susp && !susp) begin
      next_cmd   = scc_pkg::RST_CMD;
      next_cdiv  = scc_pkg::RST_CDIV;
      next_lte   = scc_pkg::RST_LTE;
      next_ffs   = scc_pkg::RST_FFS;
      next_mlen  = scc_pkg::RST_MLEN;
      next_state = scc_pkg::ST_IDLE;
    end
  end
  // Register stage; power-on clears everything to defaults
  always_ff @(posedge CLK) begin
    if (por) begin
      cmd_reg  <= scc_pkg::RST_CMD;
      cdiv     <= scc_pkg::RST_CDIV;
      lte      <= scc_pkg::RST_LTE;
      ffs      <= scc_pkg::RST_FFS;
      mlen     <= scc_pkg::RST_MLEN;
      state    <= scc_pkg::ST_IDLE;
      step_cnt <= 16'h0000;
      tick_cnt <= 16'h0000;
      step     <= 1'b0;
      acc      <= 7'h00;
      tick     <= 1'b0;
      idle_cnt <= 17'h0_0000;
      susp     <= 1'b0;
      inited   <= 1'b0;
      wake     <= 1'b0;
      rdata    <= 8'h00;
    end else begin
      cmd_reg  <= next_cmd;
      cdiv     <= next_cdiv;
      lte      <= next_lte;
      ffs      <= next_ffs;
      mlen     <= next_mlen;
      state    <= next_state;
      step_cnt <= next_step_cnt;
      tick_cnt <= next_tick_cnt;
      step     <= next_step;
      acc      <= next_acc;
      tick     <= next_tick;
      idle_cnt <= next_idle_cnt;
      susp     <= next_susp;
      inited   <= next_inited;
      wake     <= next_wake;
      rdata    <= next_rdata;
    end
  end
  // Timing figures for the sensor path, registered
  logic [9:0] next_pix;
  logic [8:0] next_lmul;
  always_comb begin
    // Half-step divider units, so C*8 becomes C*4
    next_pix  = 10'(div_half * (COLOR_PIXEL_RATE ? 7'h03 : 7'h01)
                   * 7'(scc_pkg::PIX_PER_HALF));
    next_lmul = {1'b0, lte} + 9'h001;
  end
  always_ff @(posedge CLK) begin
    if (por) begin
      PIXEL_PERIOD <= 10'h000;
      LINE_MULT    <= 9'h001;
      USB_XCVR_RST <= 1'b1;
    end else begin
      PIXEL_PERIOD <= next_pix;
      LINE_MULT    <= next_lmul;
      USB_XCVR_RST <= 1'b0;
    end
  end
  // ****************************************
  // Outputs
  // ****************************************
  assign REG_RDATA       = rdata;
  assign IMG_RD          = REG_RD & (REG_ADDR == scc_pkg::ADDR_IMAGE);
  assign CORE_TICK       = tick;
  assign MOTOR_STEP      = step;
  assign MOTOR_DIR       = (state == scc_pkg::ST_REV) || (state == scc_pkg::ST_PREV);
  assign MOTOR_OE        = MOTOR_OE_CFG & ~cmd_reg[scc_pkg::BIT_STBY] & ~susp;
  assign ANALOG_PWR_DN   = cmd_reg[scc_pkg::BIT_STBY] | susp;
  assign SCANNING        = state == scc_pkg::ST_SCAN;
  assign MOTOR_BUSY      = stepping;
  assign CORE_CLK_RUN    = ~cmd_reg[scc_pkg::BIT_SRST] & ~susp;
  assign DRAM_REFRESH_EN = CORE_CLK_RUN;
  assign OSC_RUN         = ~susp;
  assign REMOTE_WAKE     = wake;
  // Pins 1-3 stay inputs, 4-6 driven from the given values
  assign MISC_IO_OE      = scc_pkg::MISC_OE_POR;
  assign MISC_IO_OUT     = {MISC_OUT_VAL, 3'h0};
  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (por);
  a_fwd_start: assert property (cmd_wr && REG_WDATA == 8'h01 |=> state == scc_pkg::ST_FWD)
    else $error("forward feed not started");
  a_rev_start: assert property (cmd_wr && REG_WDATA == 8'h02 |=> MOTOR_DIR && MOTOR_BUSY)
    else $error("reverse feed not started");
  a_abort_idle: assert property (cmd_wr && REG_WDATA == 8'h00 |=> !MOTOR_BUSY && !SCANNING)
    else $error("zero command did not stop");
  a_rev_no_eject: assert property (MOTOR_DIR |=> state != scc_pkg::ST_EJECT)
    else $error("reverse went to eject");
  a_prog_bound: assert property (state == scc_pkg::ST_PFWD || state == scc_pkg::ST_PREV
                                 |-> step_cnt < mlen)
    else $error("programmed move overran");
  a_lead_bound: assert property (state == scc_pkg::ST_LEAD |-> step_cnt < mlen)
    else $error("lead-in overran");
  a_div_gap: assert property (cdiv[5:0] >= 6'h02 && CORE_TICK |=> !CORE_TICK)
    else $error("divider ticks too close");
  a_stby_motor: assert property (cmd_reg[scc_pkg::BIT_STBY] |-> !MOTOR_OE && ANALOG_PWR_DN)
    else $error("standby left motor enabled");
  a_srst_halt: assert property (cmd_reg[scc_pkg::BIT_SRST] |=> !CORE_TICK && !MOTOR_BUSY)
    else $error("soft reset left logic running");
  a_por_dflt: assert property (disable iff (1'b0) por |=> cmd_reg == scc_pkg::RST_CMD)
    else $error("defaults not restored");
  c_fwd: cover property (state == scc_pkg::ST_FWD ##1 state == scc_pkg::ST_IDLE);
  c_scan: cover property (state == scc_pkg::ST_LEAD ##1 state == scc_pkg::ST_SCAN);
  c_eject: cover property (state == scc_pkg::ST_EJECT);
  c_susp: cover property (!OSC_RUN);
endmodule : scc_core

/* File: core/scc_pkg.sv */
// Constants and types for the scanner command and power control block
package scc_pkg;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] ADDR_IMAGE   = 8'h00;
  localparam logic [7:0] ADDR_CMD     = 8'h07;
  localparam logic [7:0] ADDR_CDIV    = 8'h08;
  localparam logic [7:0] ADDR_LTE     = 8'h19;
  localparam logic [7:0] ADDR_FFS_HI  = 8'h48;
  localparam logic [7:0] ADDR_FFS_LO  = 8'h49;
  localparam logic [7:0] ADDR_MLEN_HI = 8'h4a;
  localparam logic [7:0] ADDR_MLEN_LO = 8'h4b;
  // ****************************************
  // Command field codes and control bits
  // ****************************************
  localparam logic [3:0] CMD_IDLE = 4'h0;
  localparam logic [3:0] CMD_FWD  = 4'h1;
  localparam logic [3:0] CMD_REV  = 4'h2;
  localparam logic [3:0] CMD_SCAN = 4'h3;
  localparam logic [3:0] CMD_PFWD = 4'h5;
  localparam logic [3:0] CMD_PREV = 4'h6;
  localparam int         BIT_STBY = 4;
  localparam int         BIT_SRST = 5;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0]  RST_CMD  = 8'h30;
  localparam logic [7:0]  RST_CDIV = 8'h00;
  localparam logic [7:0]  RST_LTE  = 8'h00;
  localparam logic [15:0] RST_FFS  = 16'h0001;
  localparam logic [15:0] RST_MLEN = 16'h0000;
  localparam logic [5:0]  MISC_OE_POR = 6'h38;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ       = 40000000;
  localparam int SUSPEND_MS   = 3;
  localparam int SUSPEND_CYC  = SUSPEND_MS * (CLK_HZ / 1000);
  localparam int PIX_PER_HALF = 4;
  // Motion states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_FWD   = 3'b001,
    ST_REV   = 3'b010,
    ST_PFWD  = 3'b011,
    ST_PREV  = 3'b100,
    ST_LEAD  = 3'b101,
    ST_SCAN  = 3'b110,
    ST_EJECT = 3'b111
  } scc_state_type;
endpackage : scc_pkg

/* File: bench/scc_host.sv */
// Host driver model that reaches the core through its register port
`timescale 1ns/1ps
module scc_host (
  input  wire logic       CLK,
  output logic            REG_WR,
  output logic            REG_RD,
  output logic      [7:0] REG_ADDR,
  output logic      [7:0] REG_WDATA,
  input  wire logic [7:0] REG_RDATA
);
  // Bus idle at time zero, address parked on an unmapped place
  initial begin
    REG_WR    = 1'b0;
    REG_RD    = 1'b0;
    REG_ADDR  = 8'h7f;
    REG_WDATA = 8'h00;
  end
  // One write; an edge passes with the strobe low before the next cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    REG_ADDR  <= a;
    REG_WDATA <= d;
    REG_WR    <= 1'b1;
    @(posedge CLK);
    REG_WR    <= 1'b0;
    REG_WDATA <= ~d;
    @(posedge CLK);
  endtask : wr
  // One read; data is registered, so it is taken one edge after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    REG_ADDR <= a;
    REG_RD   <= 1'b1;
    @(posedge CLK);
    REG_RD   <= 1'b0;
    @(posedge CLK);
    d = REG_RDATA;
  endtask : rd
  // Idle, mask sampling, reset, restore, idle again
  task automatic soft_reset();
    wr(8'h07, 8'h00);
    wr(8'h18, 8'h18);
    wr(8'h07, 8'h20);
    wr(8'h18, 8'h00);
    wr(8'h07, 8'h00);
  endtask : soft_reset
endmodule : scc_host

/* File: bench/tb.sv */
// Self-checking testbench for the scanner command and power control core
`timescale 1ns/1ps
module tb;
  // ****************
  // Signals
  // ****************
  logic       CLK = 1'b0;
  logic       SYS_RST = 1'b1;
  logic       REG_WR, REG_RD, IMG_RD, CORE_TICK, MOTOR_STEP, MOTOR_DIR, MOTOR_OE;
  logic       SCANNING, MOTOR_BUSY, ANALOG_PWR_DN, CORE_CLK_RUN, DRAM_REFRESH_EN;
  logic       OSC_RUN, USB_XCVR_RST, REMOTE_WAKE;
  logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA;
  logic [7:0] IMG_DATA = 8'h00;
  logic [1:0] PAPER_SENSE = 2'b00;
  logic [1:0] SENSE_STOP_EN = 2'b11;
  logic [7:0] EJECT_STEPS = 8'h03;
  logic       COLOR_PIXEL_RATE = 1'b0;
  logic       MOTOR_OE_CFG = 1'b1;
  logic       RESET_PIN = 1'b0;
  logic       USB_ACTIVITY = 1'b1;
  logic [5:0] MISC_IO_IN = 6'h00;
  logic [2:0] MISC_OUT_VAL = 3'b101;
  logic [5:0] MISC_IO_OUT, MISC_IO_OE;
  logic [9:0] PIXEL_PERIOD;
  logic [8:0] LINE_MULT;
  int         fails = 0;
  int         total_checks = 0;
  int         steps = 0;            // Step pulses seen
  int         ticks = 0;            // Core ticks seen
  int         imgs = 0;             // Image strobes seen
  int         wakes = 0;            // Wake pulses seen
  logic [7:0] rv;
  int         s0, i;
  // Register rows: address, write data, read-back value
  logic [23:0] reg_rows [6] = '{24'h08_0505, 24'h19_0303, 24'h48_1212,
                                24'h49_3434, 24'h4a_7777, 24'h55_aa00};
  // Rate rows: divider, extension, colour, pixel period, line factor
  logic [47:0] pix_rows [3] = '{48'h0000_0000_8001, 48'h3fff_0130_c100,
                                48'h0303_0103_c004};
  logic [7:0]  pcode [2] = '{8'h05, 8'h06};
  // ****************
  // Clock, counters, design and host
  // ****************
  always #12.5 CLK = ~CLK;
  // Counted by non-blocking update so a read at an edge never races
  always @(posedge CLK) begin
    steps <= steps + int'(MOTOR_STEP === 1'b1);
    ticks <= ticks + int'(CORE_TICK === 1'b1);
    imgs  <= imgs + int'(IMG_RD === 1'b1);
    wakes <= wakes + int'(REMOTE_WAKE === 1'b1);
  end
  scc_core #(.SUSPEND_CYCLES(50)) uut (
    .CLK(CLK), .SYS_RST(SYS_RST), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .IMG_DATA(IMG_DATA), .IMG_RD(IMG_RD), .PAPER_SENSE(PAPER_SENSE),
    .SENSE_STOP_EN(SENSE_STOP_EN), .EJECT_STEPS(EJECT_STEPS),
    .COLOR_PIXEL_RATE(COLOR_PIXEL_RATE), .MOTOR_OE_CFG(MOTOR_OE_CFG),
    .RESET_PIN(RESET_PIN), .USB_ACTIVITY(USB_ACTIVITY), .MISC_IO_IN(MISC_IO_IN),
    .MISC_OUT_VAL(MISC_OUT_VAL), .MISC_IO_OUT(MISC_IO_OUT), .MISC_IO_OE(MISC_IO_OE),
    .CORE_TICK(CORE_TICK), .MOTOR_STEP(MOTOR_STEP), .MOTOR_DIR(MOTOR_DIR),
    .MOTOR_OE(MOTOR_OE), .SCANNING(SCANNING), .MOTOR_BUSY(MOTOR_BUSY),
    .ANALOG_PWR_DN(ANALOG_PWR_DN), .CORE_CLK_RUN(CORE_CLK_RUN),
    .DRAM_REFRESH_EN(DRAM_REFRESH_EN), .OSC_RUN(OSC_RUN),
    .USB_XCVR_RST(USB_XCVR_RST), .REMOTE_WAKE(REMOTE_WAKE),
    .PIXEL_PERIOD(PIXEL_PERIOD), .LINE_MULT(LINE_MULT));
  scc_host host (.CLK(CLK), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR),
                 .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA));
  // ****************
  // Helpers
  // ****************
  // Compare values, case equality so unknowns fail
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val
  // Compare one flag
  task automatic chk_bit(input logic got, input logic exp);
    chk_val({15'h0000, got}, {15'h0000, exp});
  endtask : chk_bit
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
  endtask : cyc
  // Bounded wait for motion to end; a hang shows as busy still high
  task automatic wait_idle();
    int n;
    for (n = 0; n < 400 && MOTOR_BUSY !== 1'b0; n++) @(posedge CLK);
    cyc(3);
  endtask : wait_idle
  task automatic give_verdict();
    if (fails == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  // Watchdog sized well above the whole sequence
  initial begin
    #500000;
    fails++;
    give_verdict();
  end
  // ****************
  // Main sequence
  // ****************
  initial begin
    cyc(5);
    chk_bit(USB_XCVR_RST, 1'b1);
    SYS_RST <= 1'b0;
    cyc(1);
    host.rd(8'h07, rv);
    chk_val(rv, 8'h30);
    chk_bit(USB_XCVR_RST, 1'b0);
    chk_val(MISC_IO_OE, 6'h38);
    chk_val(MISC_IO_OUT, {MISC_OUT_VAL, 3'b000});
    chk_bit(ANALOG_PWR_DN, 1'b1);
    chk_bit(MOTOR_OE, 1'b0);
    host.wr(8'h07, 8'h00);
    chk_bit(CORE_CLK_RUN, 1'b1);
    chk_bit(MOTOR_OE, 1'b1);
    // Register table, unmapped place last
    foreach (reg_rows[k]) begin
      host.wr(reg_rows[k][23:16], reg_rows[k][15:8]);
      host.rd(reg_rows[k][23:16], rv);
      chk_val(rv, reg_rows[k][7:0]);
    end
    // Image port read strobes the buffer once
    IMG_DATA <= 8'h5a;
    s0 = imgs;
    host.rd(8'h00, rv);
    chk_val(rv, 8'h5a);
    chk_val(imgs - s0, 1);
    // Divider, pixel period and line factor rows
    foreach (pix_rows[k]) begin
      host.wr(8'h08, pix_rows[k][47:40]);
      host.wr(8'h19, pix_rows[k][39:32]);
      COLOR_PIXEL_RATE <= pix_rows[k][24];
      cyc(4);
      chk_val(PIXEL_PERIOD, pix_rows[k][23:12]);
      chk_val(LINE_MULT, pix_rows[k][11:0]);
      s0 = ticks;
      cyc(130);
      chk_val(ticks - s0, 260 / (pix_rows[k][47:40] + 2));
    end
    host.wr(8'h08, 8'h00);
    // Free forward feed at step size 4
    host.wr(8'h48, 8'h00);
    host.wr(8'h49, 8'h04);
    host.wr(8'h4a, 8'h00);
    host.wr(8'h4b, 8'h04);
    host.wr(8'h07, 8'h01);
    cyc(8);
    chk_bit(MOTOR_BUSY, 1'b1);
    chk_bit(MOTOR_DIR, 1'b0);
    s0 = steps;
    cyc(40);
    chk_val(steps - s0, 10);
    host.wr(8'h07, 8'h00);
    chk_bit(MOTOR_BUSY, 1'b0);
    // Sensor stops at step size 16: reverse stops at once, forward ejects
    host.wr(8'h49, 8'h10);
    host.wr(8'h07, 8'h02);
    cyc(1);
    chk_bit(MOTOR_DIR, 1'b1);
    s0 = steps;
    PAPER_SENSE <= 2'b10;
    wait_idle();
    chk_bit(MOTOR_BUSY, 1'b0);
    chk_val(steps - s0, 0);
    PAPER_SENSE <= 2'b00;
    cyc(4);
    host.wr(8'h07, 8'h01);
    s0 = steps;
    PAPER_SENSE <= 2'b10;
    wait_idle();
    chk_bit(MOTOR_BUSY, 1'b0);
    chk_val(steps - s0, 3);
    PAPER_SENSE <= 2'b00;
    cyc(4);
    // Programmed moves stop after the move length
    foreach (pcode[k]) begin
      s0 = steps;
      host.wr(8'h07, pcode[k]);
      cyc(1);
      chk_bit(MOTOR_DIR, pcode[k][1]);
      wait_idle();
      chk_bit(MOTOR_BUSY, 1'b0);
      chk_val(steps - s0, 4);
    end
    // Disabled sensor is ignored; a zero eject count stops at once
    SENSE_STOP_EN <= 2'b01;
    EJECT_STEPS   <= 8'h00;
    host.wr(8'h07, 8'h01);
    PAPER_SENSE <= 2'b10;
    cyc(8);
    chk_bit(MOTOR_BUSY, 1'b1);
    SENSE_STOP_EN <= 2'b11;
    PAPER_SENSE   <= 2'b00;
    cyc(4);
    PAPER_SENSE <= 2'b10;
    cyc(6);
    chk_bit(MOTOR_BUSY, 1'b0);
    PAPER_SENSE <= 2'b00;
    EJECT_STEPS <= 8'h03;
    cyc(4);
    // Scan: lead-in of move length, then scanning without steps
    s0 = steps;
    host.wr(8'h07, 8'h03);
    for (i = 0; i < 400 && SCANNING !== 1'b1; i++) @(posedge CLK);
    cyc(3);
    chk_bit(SCANNING, 1'b1);
    chk_val(steps - s0, 4);
    host.wr(8'h07, 8'h00);
    chk_bit(SCANNING, 1'b0);
    // Motor enable follows its configuration outside standby
    MOTOR_OE_CFG <= 1'b0;
    cyc(1);
    chk_bit(MOTOR_OE, 1'b0);
    MOTOR_OE_CFG <= 1'b1;
    // Standby keeps register access
    host.wr(8'h07, 8'h10);
    chk_bit(MOTOR_OE, 1'b0);
    chk_bit(ANALOG_PWR_DN, 1'b1);
    host.rd(8'h07, rv);
    chk_val(rv, 8'h10);
    // Soft reset overrides a motion code
    host.wr(8'h07, 8'h21);
    cyc(1);
    chk_bit(MOTOR_BUSY, 1'b0);
    chk_bit(CORE_CLK_RUN, 1'b0);
    chk_bit(DRAM_REFRESH_EN, 1'b0);
    chk_bit(OSC_RUN, 1'b1);
    host.wr(8'h08, 8'h07);
    host.rd(8'h08, rv);
    chk_val(rv, 8'h07);
    host.soft_reset();
    chk_bit(CORE_CLK_RUN, 1'b1);
    // Reset pin pulse clears like power-up
    host.wr(8'h19, 8'h55);
    RESET_PIN <= 1'b1;
    cyc(3);
    RESET_PIN <= 1'b0;
    cyc(6);
    host.rd(8'h19, rv);
    chk_val(rv, 8'h00);
    host.rd(8'h07, rv);
    chk_val(rv, 8'h30);
    // Suspend after bus silence, wake from spare pin, then exit
    host.wr(8'h07, 8'h00);
    host.wr(8'h08, 8'h09);
    USB_ACTIVITY <= 1'b0;
    cyc(70);
    chk_bit(OSC_RUN, 1'b0);
    chk_bit(MOTOR_OE, 1'b0);
    s0 = wakes;
    MISC_IO_IN <= 6'h01;
    cyc(8);
    chk_val(wakes - s0, 1);
    USB_ACTIVITY <= 1'b1;
    cyc(5);
    chk_bit(OSC_RUN, 1'b1);
    host.rd(8'h07, rv);
    chk_val(rv, 8'h30);
    host.rd(8'h08, rv);
    chk_val(rv, 8'h00);
    give_verdict();
  end
endmodule : tb
